// *** hdl/aris_defines.vh ***
`ifndef ARIS_DEFINES_VH
`define ARIS_DEFINES_VH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define ARIS_ADDR_RX_ERR        7'h18
`define ARIS_ADDR_RX_ERR_MASK   7'h19
`define ARIS_ADDR_CONV_ERR      7'h1a
`define ARIS_ADDR_CONV_ERR_MASK 7'h1b
`define ARIS_ADDR_INT_STATUS    7'h1c

// ----------------------------------------------------------------------
// Receiver error bit positions
// ----------------------------------------------------------------------
`define ARIS_RX_VALIDITY        7
`define ARIS_RX_EMPHASIS        6
`define ARIS_RX_NON_PCM         5
`define ARIS_RX_NON_PCM_PRE     4
`define ARIS_RX_CHECKSUM        3
`define ARIS_RX_INPUT_ABSENT    2
`define ARIS_RX_LINE_CODE       1
`define ARIS_RX_LOCK            0
// Bits that latch until read; the others follow a level.
`define ARIS_RX_STICKY_BITS     8'h0a

// ----------------------------------------------------------------------
// Converter error bit positions
// ----------------------------------------------------------------------
`define ARIS_CV_CLOCK_SHORT     3
`define ARIS_CV_LEFT_CLIP       2
`define ARIS_CV_RIGHT_CLIP      1
`define ARIS_CV_FAST_WARN       0
`define ARIS_CV_MASK_BITS       3'h7
`define ARIS_CV_STICKY_BITS     3'h6

// ----------------------------------------------------------------------
// Interrupt status bit positions
// ----------------------------------------------------------------------
`define ARIS_IS_CONV_ERR        7
`define ARIS_IS_TX_COLLISION    6
`define ARIS_IS_TX_UB_EMPTY     5
`define ARIS_IS_TX_CS_DONE      4
`define ARIS_IS_CH_MISMATCH     3
`define ARIS_IS_RX_USER         2
`define ARIS_IS_RX_CS           1
`define ARIS_IS_RX_ERR          0
// The channel mismatch bit never reaches the interrupt output.
`define ARIS_IS_IRQ_BITS        8'hf7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ARIS_RST_BYTE           8'h00
`define ARIS_RST_NIBBLE         4'h0
`define ARIS_RST_TRIPLE         3'h0

`endif

// *** hdl/aris_irq_status.v ***
// Summary of operation
// - Receiver error mask bit 1 lets its flag interrupt; 0 blocks it.
// - Mask 0x19 bits 7..0: validity,emphasis,non-PCM,preamble,crc,absent,line,lock.
// - Converter error bit 3 set when converter clock is too short.
// - Left clip bit 2 latches until converter error register is read.
// - Right clip bit 1 latches until converter error register is read.
// - Fast-mode warning bit 0 follows state; interrupts again only on change.
// - Converter mask 0x1b gates bits 2,1,0; clock-short has no mask and never interrupts.
// - Interrupt status bit 7 set on converter interrupt, held until read.
// - Bit 6 set on host write collision during channel-status copy.
// - Bit 5 set when transmit buffer empties, held until read.
// - Bit 4 set when channel-status block sent, held until read.
// - Bit 3 set on channel A/B mismatch, held, never interrupts.
// - Bit 2 set on new receive user block, held until read.
// - Bit 1 set per block, or on change when config bit is 1.
// - Bit 0 set on receiver interrupt, held until status is read.
// - Line-code error latches until receiver error register is read.
// - Input-absent follows state; interrupts again only on change.
`timescale 1ns/1ps
`include "aris_defines.vh"

module aris_irq_status
(
    // Clock and reset
    input  wire       clk_in,
    input  wire       rstn_in,
    // Register access from the serial port decoder
    input  wire [6:0] reg_addr_in,
    input  wire       reg_wr_in,
    input  wire       reg_rd_in,
    input  wire [7:0] reg_wdata_in,
    output reg  [7:0] reg_rdata_out,
    // Receiver conditions: pulses for latched bits, levels for others
    input  wire [7:0] rx_error_cond_in,
    // Converter conditions
    input  wire       clock_short_in,
    input  wire       left_clip_in,
    input  wire       right_clip_in,
    input  wire       fast_mode_click_warn_in,
    // Transmitter and receiver buffer events (one-cycle pulses), plus the config bit 3 level
    input  wire       tx_cs_write_collision_in,
    input  wire       tx_user_buffer_empty_in,
    input  wire       tx_cs_block_done_in,
    input  wire       rx_cs_channel_mismatch_in,
    input  wire       rx_user_block_new_in,
    input  wire       rx_cs_block_new_in,
    input  wire       rx_cs_changed_in,
    input  wire       rx_buffer_cfg_bit3_in,
    // Interrupt request, active high
    output reg        irq_out
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    reg  [7:0] receiver_error_mask;
    reg  [7:0] rx_flag;
    reg  [7:0] rx_pend;
    reg  [2:0] converter_error_mask;
    reg  [2:0] cv_flag;
    reg  [2:0] cv_pend;
    reg        clock_short;
    reg  [7:0] interrupt_summary_status;

    wire       rd_rx  = reg_rd_in && (reg_addr_in == `ARIS_ADDR_RX_ERR);
    wire       rd_cv  = reg_rd_in && (reg_addr_in == `ARIS_ADDR_CONV_ERR);
    wire       rd_is  = reg_rd_in && (reg_addr_in == `ARIS_ADDR_INT_STATUS);
    wire [7:0] sticky_rx = `ARIS_RX_STICKY_BITS;
    wire [2:0] sticky_cv = `ARIS_CV_STICKY_BITS;
    wire [2:0] cv_cond = {left_clip_in, right_clip_in,
                          fast_mode_click_warn_in};

    // ------------------------------------------------------------------
    // Mask registers
    // ------------------------------------------------------------------
    always @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            receiver_error_mask  <= `ARIS_RST_BYTE;
            converter_error_mask <= `ARIS_RST_TRIPLE;
        end
        else if (reg_wr_in)
        begin
            if (reg_addr_in == `ARIS_ADDR_RX_ERR_MASK)
                receiver_error_mask <= reg_wdata_in;
            if (reg_addr_in == `ARIS_ADDR_CONV_ERR_MASK)
                converter_error_mask <= reg_wdata_in[2:0];
        end
    end

    // ------------------------------------------------------------------
    // Receiver and converter error flags
    // ------------------------------------------------------------------
    // Latched bits hold the event until read; a new event in the read
    // cycle wins so it is not lost. Level bits show the live state and
    // are pending only after a change, so a steady state that has been
    // read does not keep the interrupt asserted.
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1)
        begin : g_rx
            always @(posedge clk_in or negedge rstn_in)
            begin
                if (!rstn_in)
                begin
                    rx_flag[i] <= 1'b0;
                    rx_pend[i] <= 1'b0;
                end
                else if (sticky_rx[i])
                begin
                    rx_flag[i] <= rx_error_cond_in[i] |
                                  (rx_flag[i] & ~rd_rx);
                    rx_pend[i] <= rx_error_cond_in[i] |
                                  (rx_flag[i] & ~rd_rx);
                end
                else
                begin
                    rx_flag[i] <= rx_error_cond_in[i];
                    rx_pend[i] <= (rx_error_cond_in[i] ^ rx_flag[i]) |
                                  (rx_pend[i] & ~rd_rx);
                end
            end
        end
        for (i = 0; i < 3; i = i + 1)
        begin : g_cv
            always @(posedge clk_in or negedge rstn_in)
            begin
                if (!rstn_in)
                begin
                    cv_flag[i] <= 1'b0;
                    cv_pend[i] <= 1'b0;
                end
                else if (sticky_cv[i])
                begin
                    cv_flag[i] <= cv_cond[i] | (cv_flag[i] & ~rd_cv);
                    cv_pend[i] <= cv_cond[i] | (cv_flag[i] & ~rd_cv);
                end
                else
                begin
                    cv_flag[i] <= cv_cond[i];
                    cv_pend[i] <= (cv_cond[i] ^ cv_flag[i]) |
                                  (cv_pend[i] & ~rd_cv);
                end
            end
        end
    endgenerate

    always @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            clock_short <= 1'b0;
        else
            clock_short <= clock_short_in;
    end

    // ------------------------------------------------------------------
    // Interrupt summary status
    // ------------------------------------------------------------------
    // The summaries re-set after a status read while the detail flag is
    // still pending, which is why the host must read the detail too.
    wire rx_irq  = |(rx_pend & receiver_error_mask);
    wire cv_irq  = |(cv_pend & converter_error_mask);
    wire cs_evt  = rx_buffer_cfg_bit3_in ? rx_cs_changed_in
                                         : rx_cs_block_new_in;
    wire [7:0] is_set = {cv_irq,
                         tx_cs_write_collision_in,
                         tx_user_buffer_empty_in,
                         tx_cs_block_done_in,
                         rx_cs_channel_mismatch_in,
                         rx_user_block_new_in,
                         cs_evt,
                         rx_irq};
    wire [7:0] next_status = is_set |
                             (interrupt_summary_status & {8{~rd_is}});
    wire [7:0] irq_bits = `ARIS_IS_IRQ_BITS;

    always @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            interrupt_summary_status <= `ARIS_RST_BYTE;
            irq_out                  <= 1'b0;
        end
        else
        begin
            interrupt_summary_status <= next_status;
            irq_out <= |(next_status & irq_bits);
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            reg_rdata_out <= `ARIS_RST_BYTE;
        else if (reg_rd_in)
        begin
            case (reg_addr_in)
                `ARIS_ADDR_RX_ERR:        reg_rdata_out <= rx_flag;
                `ARIS_ADDR_RX_ERR_MASK:   reg_rdata_out <= receiver_error_mask;
                `ARIS_ADDR_CONV_ERR:
                    reg_rdata_out <= {`ARIS_RST_NIBBLE, clock_short,
                                      cv_flag};
                `ARIS_ADDR_CONV_ERR_MASK:
                    reg_rdata_out <= {5'h00, converter_error_mask};
                `ARIS_ADDR_INT_STATUS:
                    reg_rdata_out <= interrupt_summary_status;
                default:                  reg_rdata_out <= `ARIS_RST_BYTE;
            endcase
        end
    end

endmodule // aris_irq_status

// *** testbench/aris_host_model.sv ***
`timescale 1ns/1ps
module aris_host_model
(
    // Register port toward the device
    input  wire       clk_in,
    input  wire [7:0] rdata_in,
    output reg  [6:0] addr_out,
    output reg        wr_out,
    output reg        rd_out,
    output reg  [7:0] wdata_out
);
    initial
    begin
        addr_out = 7'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = 8'h00;
    end
    // Released write data is inverted so a stale byte never looks valid.
    task wr(input [6:0] a, input [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        wdata_out <= ~d;
    endtask
    task rd(input [6:0] a, output [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        #1 d = rdata_in;
    endtask
endmodule // aris_host_model

// *** testbench/aris_irq_asserts.sv ***
`timescale 1ns/1ps
module aris_irq_asserts
(
    // Clock, reset and watched ports
    input wire       clk_in,
    input wire       rstn_in,
    input wire [6:0] reg_addr_in,
    input wire       reg_rd_in,
    input wire [7:0] reg_rdata_out,
    input wire       tx_cs_write_collision_in,
    input wire       tx_user_buffer_empty_in,
    input wire       tx_cs_block_done_in,
    input wire       rx_user_block_new_in,
    input wire       rx_cs_block_new_in,
    input wire       rx_buffer_cfg_bit3_in,
    input wire       irq_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);
    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    tx_coll_irq_a: assert property (
        tx_cs_write_collision_in |=> irq_out) else $error("no irq");
    tx_empty_irq_a: assert property (
        tx_user_buffer_empty_in |=> irq_out) else $error("no irq");
    tx_done_irq_a: assert property (
        tx_cs_block_done_in |-> ##1 irq_out) else $error("no irq");
    rx_user_irq_a: assert property (
        rx_user_block_new_in |=> irq_out) else $error("no irq");
    rx_cs_irq_a: assert property (
        rx_cs_block_new_in && !rx_buffer_cfg_bit3_in |=> irq_out)
        else $error("no irq");
    irq_fall_read_a: assert property (
        $fell(irq_out) |-> $past(reg_rd_in) && $past(reg_addr_in) == 7'h1c)
        else $error("irq fell without status read");
    cv_mask_rsv_a: assert property (
        reg_rd_in && reg_addr_in == 7'h1b |=> reg_rdata_out[7:3] == 5'h00)
        else $error("mask reserved bits set");
    cv_err_rsv_a: assert property (
        reg_rd_in && reg_addr_in == 7'h1a |=> reg_rdata_out[7:4] == 4'h0)
        else $error("error reserved bits set");
    cover property (tx_user_buffer_empty_in ##1 irq_out);
    cover property ($fell(irq_out));
    cover property (reg_rd_in && reg_addr_in == 7'h1a);
endmodule // aris_irq_asserts

bind aris_irq_status aris_irq_asserts u_chk (.*);

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    reg        clk_in = 1'b0;
    reg        rstn_in = 1'b0;
    reg  [8:0] ev = 9'h000;
    reg  [7:0] cond = 8'h00;
    reg        cs = 1'b0;
    reg        fw = 1'b0;
    reg        cfg = 1'b0;
    wire [6:0] addr;
    wire       wr;
    wire       rd;
    wire [7:0] wdata;
    wire [7:0] rdata;
    wire       irq;
    integer    bad_count = 0;
    integer    total_checks = 0;
    integer    cyc = 0;
    integer    i;
    localparam [55:0] EXP = 56'h00_02_04_08_10_20_40;
    aris_host_model u_host (.clk_in(clk_in), .rdata_in(rdata),
        .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata));
    aris_irq_status dut (.clk_in(clk_in), .rstn_in(rstn_in),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .rx_error_cond_in(cond), .clock_short_in(cs),
        .left_clip_in(ev[7]), .right_clip_in(ev[8]),
        .fast_mode_click_warn_in(fw), .tx_cs_write_collision_in(ev[0]),
        .tx_user_buffer_empty_in(ev[1]), .tx_cs_block_done_in(ev[2]),
        .rx_cs_channel_mismatch_in(ev[3]), .rx_user_block_new_in(ev[4]),
        .rx_cs_block_new_in(ev[5]), .rx_cs_changed_in(ev[6]),
        .rx_buffer_cfg_bit3_in(cfg), .irq_out(irq));
    initial
    begin
        forever #2 clk_in = ~clk_in;
    end
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            bad_count = bad_count + 1;
            stop_test;
        end
    end
    task chk(input [7:0] g, input [7:0] e);
        total_checks = total_checks + 1;
        if (g !== e)
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        if (g !== e)
            bad_count = bad_count + 1;
    endtask
    task rc(input [6:0] a, input [7:0] e);
        reg [7:0] d;
        u_host.rd(a, d);
        chk(d, e);
    endtask
    // --------------------------------------------------------------
    // Events are one-cycle pulses; two edges let the summary land.
    // --------------------------------------------------------------
    task pulse(input integer n);
        @(posedge clk_in) ev[n] <= 1'b1;
        @(posedge clk_in) ev[n] <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
    endtask
    task lvl(input [7:0] c, input s, input f);
        @(posedge clk_in) cond <= c;
        cs <= s;
        fw <= f;
        repeat (3) @(posedge clk_in);
        #1;
    endtask
    initial
    begin
        repeat (10) @(posedge clk_in);
        rstn_in <= 1'b1;
        u_host.wr(7'h19, 8'ha5);
        rc(7'h19, 8'ha5);
        u_host.wr(7'h1b, 8'hff);
        rc(7'h1b, 8'h07);
        rc(7'h1a, 8'h00);
        rc(7'h1c, 8'h00);
        rc(7'h00, 8'h00);
        for (i = 0; i < 7; i = i + 1)
        begin
            pulse(i);
            chk({7'h00, irq}, {7'h00, |(EXP[i*8+:8] & 8'hf7)});
            rc(7'h1c, EXP[i*8+:8]);
            chk({7'h00, irq}, 8'h00);
        end
        cfg <= 1'b1;
        pulse(5);
        rc(7'h1c, 8'h00);
        pulse(6);
        rc(7'h1c, 8'h02);
        pulse(7);
        rc(7'h1a, 8'h04);
        rc(7'h1c, 8'h80);
        rc(7'h1c, 8'h00);
        rc(7'h1a, 8'h00);
        u_host.wr(7'h1b, 8'h01);
        pulse(8);
        rc(7'h1a, 8'h02);
        rc(7'h1c, 8'h00);
        lvl(8'h00, 1'b1, 1'b0);
        chk({7'h00, irq}, 8'h00);
        rc(7'h1a, 8'h08);
        lvl(8'h00, 1'b0, 1'b1);
        rc(7'h1a, 8'h01);
        rc(7'h1c, 8'h80);
        rc(7'h1c, 8'h00);
        rc(7'h1a, 8'h01);
        u_host.wr(7'h19, 8'h06);
        lvl(8'h02, 1'b0, 1'b1);
        lvl(8'h04, 1'b0, 1'b1);
        rc(7'h18, 8'h06);
        rc(7'h1c, 8'h01);
        rc(7'h1c, 8'h00);
        rc(7'h18, 8'h04);
        lvl(8'h0c, 1'b0, 1'b1);
        rc(7'h1c, 8'h00);
        rc(7'h18, 8'h0c);
        stop_test;
    end
endmodule // testbench
